// ===== isp_top.sv
// Two-wire serial slave port giving a bus master access to the registers
`timescale 1ns/1ns
module isp_top (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Serial bus pins, open drain data
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Status
   output logic busActive
);
   localparam int BW = isp_pkg::BYTE_W;
   localparam int CW = isp_pkg::CNT_W;

   function automatic logic addrMatch(input logic [BW-1:0] b);
      return b[BW-1:1] == isp_pkg::SLAVE_ADDR;
   endfunction

   // Pin synchronisers and previous samples
   logic [1:0] pinIn, syncA_ff, syncB_ff, prev_ff;
   logic sclNow, sdaNow, sclPrev, sdaPrev;
   logic sclRise, sclFall, startDet, stopDet;

   // Protocol state
   isp_pkg::isp_state_t state_ff, nxt_state, after_ff, nxt_after;
   logic [BW-1:0] shift_ff, nxt_shift, ptr_ff, nxt_ptr;
   logic [CW-1:0] bitCnt_ff, nxt_bitCnt;
   logic sdaOe_ff, nxt_sdaOe, busActive_ff;

   // Byte decode
   logic [BW-1:0] rxByte, memData;
   logic rxShift, rxEnd, txEnd, memRdEn, pushReady, pushValid, inRx;

   isp_stream_if #(.W(isp_pkg::FIFO_W)) pushIf ();
   isp_stream_if #(.W(isp_pkg::FIFO_W)) drainIf ();

   assign pinIn = {sclIn, sdaIn};

   always_ff @(posedge clock) begin
      if (!resetn) begin
         syncA_ff <= isp_pkg::PIN_IDLE;
         syncB_ff <= isp_pkg::PIN_IDLE;
         prev_ff <= isp_pkg::PIN_IDLE;
      end else begin
         syncA_ff <= pinIn;
         syncB_ff <= syncA_ff;
         prev_ff <= syncB_ff;
      end
   end

   assign sclNow = syncB_ff[1];
   assign sdaNow = syncB_ff[0];
   assign sclPrev = prev_ff[1];
   assign sdaPrev = prev_ff[0];
   assign sclRise = sclNow && !sclPrev;
   assign sclFall = !sclNow && sclPrev;
   assign startDet = sclNow && sclPrev && sdaPrev && !sdaNow;
   assign stopDet = sclNow && sclPrev && !sdaPrev && sdaNow;

   assign rxByte = {shift_ff[BW-2:0], sdaNow};
   assign rxShift = sclRise && (bitCnt_ff != isp_pkg::BITS_PER_BYTE);
   assign rxEnd = sclFall && (bitCnt_ff == isp_pkg::BITS_PER_BYTE);
   assign txEnd = sclFall && (bitCnt_ff == isp_pkg::BITS_PER_BYTE);
   assign inRx = (state_ff == isp_pkg::ST_ADDR) || (state_ff == isp_pkg::ST_IDX) ||
      (state_ff == isp_pkg::ST_WDATA);

   // each data byte the buffer accepts is queued at the pointer
   assign pushValid = (state_ff == isp_pkg::ST_WDATA) && rxEnd;
   assign pushIf.valid = pushValid;
   assign pushIf.data = {ptr_ff, shift_ff};
   assign pushReady = pushIf.ready;

   // Read port busy in every acknowledge slot, the slave's and the master's, which covers the fetch of the next outgoing byte
   assign memRdEn = (state_ff == isp_pkg::ST_ACK) || (state_ff == isp_pkg::ST_RACK);

   isp_fifo #(.WIDTH(isp_pkg::FIFO_W), .DEPTH(isp_pkg::FIFO_DEPTH)) uFifo (
      .clock(clock),
      .resetn(resetn),
      .inPort(pushIf.snk),
      .outPort(drainIf.src)
   );

   isp_regmem uRegs (
      .clock(clock),
      .resetn(resetn),
      .wrPort(drainIf.snk),
      .rdEn(memRdEn),
      .rdIdx(ptr_ff),
      .rdData(memData)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_after = after_ff;
      nxt_shift = shift_ff;
      nxt_ptr = ptr_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_sdaOe = sdaOe_ff;
      if (stopDet) begin
         nxt_state = isp_pkg::ST_IDLE;
         nxt_sdaOe = 1'b0;
      end else if (startDet) begin
         nxt_state = isp_pkg::ST_ADDR;
         nxt_bitCnt = '0;
         nxt_sdaOe = 1'b0;
      end else begin
         case (state_ff)
            isp_pkg::ST_ADDR, isp_pkg::ST_IDX, isp_pkg::ST_WDATA: begin
               if (rxShift) begin
                  nxt_shift = rxByte;
                  nxt_bitCnt = bitCnt_ff + 1'b1;
               end
               if (rxEnd) begin
                  nxt_bitCnt = '0;
                  nxt_state = isp_pkg::ST_ACK;
                  nxt_sdaOe = 1'b1;
                  if (state_ff == isp_pkg::ST_ADDR) begin
                     // own address only, direction picks the phase
                     if (shift_ff[0] == isp_pkg::RW_READ) begin
                        nxt_after = isp_pkg::ST_RDATA;
                     end else begin
                        nxt_after = isp_pkg::ST_IDX;
                     end
                     if (!addrMatch(shift_ff)) begin
                        nxt_state = isp_pkg::ST_SKIP;
                        nxt_sdaOe = 1'b0;
                     end
                  end else if (state_ff == isp_pkg::ST_IDX) begin
                     nxt_ptr = shift_ff;
                     nxt_after = isp_pkg::ST_WDATA;
                  end else begin
                     nxt_after = isp_pkg::ST_WDATA;
                     if (pushReady) begin
                        nxt_ptr = ptr_ff + isp_pkg::PTR_STEP;
                     end else begin
                        // Buffer full: refuse the byte rather than lose it
                        nxt_state = isp_pkg::ST_SKIP;
                        nxt_sdaOe = 1'b0;
                     end
                  end
               end
            end
            isp_pkg::ST_ACK: begin
               // held low until the acknowledge clock falls
               if (sclFall) begin
                  nxt_state = after_ff;
                  nxt_sdaOe = 1'b0;
                  if (after_ff == isp_pkg::ST_RDATA) begin
                     // first bit of the selected register
                     nxt_shift = memData;
                     nxt_sdaOe = !memData[BW-1];
                     nxt_bitCnt = 4'h1;
                  end
               end
            end
            isp_pkg::ST_RDATA: begin
               if (txEnd) begin
                  nxt_sdaOe = 1'b0;
                  nxt_state = isp_pkg::ST_RACK;
                  nxt_ptr = ptr_ff + isp_pkg::PTR_STEP;
               end else if (sclFall) begin
                  // bits change only after the clock falls
                  nxt_shift = {shift_ff[BW-2:0], 1'b0};
                  nxt_sdaOe = !shift_ff[BW-2];
                  nxt_bitCnt = bitCnt_ff + 1'b1;
               end
            end
            isp_pkg::ST_RACK: begin
               if (sclRise) begin
                  // continue for as long as the master acknowledges
                  nxt_after = isp_pkg::ST_RDATA;
                  if (sdaNow) begin
                     nxt_state = isp_pkg::ST_SKIP;
                  end else begin
                     nxt_state = isp_pkg::ST_ACK;
                  end
               end
            end
            isp_pkg::ST_IDLE, isp_pkg::ST_SKIP: begin
               nxt_sdaOe = 1'b0;
            end
            default: begin
               nxt_state = isp_pkg::ST_IDLE;
               nxt_sdaOe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_ff <= isp_pkg::ST_IDLE;
         after_ff <= isp_pkg::ST_IDX;
         shift_ff <= '0;
         ptr_ff <= '0;
         bitCnt_ff <= '0;
         sdaOe_ff <= 1'b0;
         busActive_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         after_ff <= nxt_after;
         shift_ff <= nxt_shift;
         ptr_ff <= nxt_ptr;
         bitCnt_ff <= nxt_bitCnt;
         sdaOe_ff <= nxt_sdaOe;
         busActive_ff <= (nxt_state != isp_pkg::ST_IDLE);
      end
   end

   assign sdaOut = isp_pkg::SDA_DRIVE_LVL;
   assign sdaOe = sdaOe_ff;
   assign busActive = busActive_ff;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   a_stop_release: assert property (
      stopDet |=> state_ff == isp_pkg::ST_IDLE && !sdaOe_ff)
      else $error("stop did not return the port to idle");
   a_start_addr: assert property (
      startDet && !stopDet |=> state_ff == isp_pkg::ST_ADDR && bitCnt_ff == '0)
      else $error("start did not restart addressing");
   a_change_low: assert property (
      $changed(sdaOe_ff) && !$past(startDet) && !$past(stopDet) |-> !$past(sclNow))
      else $error("data line changed while clock high");
   a_ack_hold: assert property (
      state_ff == isp_pkg::ST_ACK && sdaOe_ff && !sclFall && !startDet && !stopDet
      |=> sdaOe_ff)
      else $error("acknowledge released early");
   a_foreign_nack: assert property (
      state_ff == isp_pkg::ST_ADDR && rxEnd && !addrMatch(shift_ff) && !stopDet && !startDet
      |=> state_ff == isp_pkg::ST_SKIP && !sdaOe_ff)
      else $error("foreign address acknowledged");
   a_idx_load: assert property (
      state_ff == isp_pkg::ST_IDX && rxEnd && !stopDet && !startDet
      |=> ptr_ff == $past(shift_ff) && sdaOe_ff)
      else $error("index byte did not load pointer");
   a_write_ack: assert property (
      pushValid && pushReady && !stopDet && !startDet
      |=> sdaOe_ff && state_ff == isp_pkg::ST_ACK && ptr_ff == BW'($past(ptr_ff) + 8'h01))
      else $error("data byte not acknowledged or pointer not advanced");
   a_read_msb: assert property (
      state_ff == isp_pkg::ST_ACK && after_ff == isp_pkg::ST_RDATA && sclFall
      && !stopDet && !startDet |=> sdaOe_ff == !$past(memData[BW-1]))
      else $error("read byte did not start with its top bit");
   a_read_inc: assert property (
      state_ff == isp_pkg::ST_RDATA && txEnd && !stopDet && !startDet
      |=> state_ff == isp_pkg::ST_RACK && ptr_ff == BW'($past(ptr_ff) + 8'h01))
      else $error("pointer not advanced after read byte");

   a_shift_msb: assert property (
      inRx && rxShift && !startDet && !stopDet
      |=> shift_ff == {$past(shift_ff[BW-2:0]), $past(sdaNow)})
      else $error("received bit not shifted in at the bottom");
   a_tx_next: assert property (
      state_ff == isp_pkg::ST_RDATA && sclFall && !txEnd && !startDet && !stopDet
      |=> sdaOe_ff == !$past(shift_ff[BW-2]) && bitCnt_ff == $past(bitCnt_ff) + 4'h1)
      else $error("sent bit out of order");
   a_ack_slot: assert property (
      inRx && rxEnd && !startDet && !stopDet
      |=> (state_ff == isp_pkg::ST_ACK || state_ff == isp_pkg::ST_SKIP) && bitCnt_ff == '0)
      else $error("ninth slot not opened after eight bits");
   a_rack_free: assert property (
      state_ff == isp_pkg::ST_RACK |-> !sdaOe_ff)
      else $error("data line held while master acknowledges");
   a_write_addr: assert property (
      state_ff == isp_pkg::ST_ADDR && rxEnd && addrMatch(shift_ff) && !startDet && !stopDet
      && shift_ff[0] != isp_pkg::RW_READ
      |=> state_ff == isp_pkg::ST_ACK && sdaOe_ff && after_ff == isp_pkg::ST_IDX)
      else $error("own write address not acknowledged");
   a_read_addr: assert property (
      state_ff == isp_pkg::ST_ADDR && rxEnd && addrMatch(shift_ff) && !startDet && !stopDet
      && shift_ff[0] == isp_pkg::RW_READ
      |=> state_ff == isp_pkg::ST_ACK && sdaOe_ff && after_ff == isp_pkg::ST_RDATA)
      else $error("own read address not acknowledged");
   a_more_read: assert property (
      state_ff == isp_pkg::ST_RACK && sclRise && !sdaNow && !startDet && !stopDet
      |=> state_ff == isp_pkg::ST_ACK && after_ff == isp_pkg::ST_RDATA && !sdaOe_ff)
      else $error("master acknowledge did not continue the read");
   a_nack_quit: assert property (
      state_ff == isp_pkg::ST_RACK && sclRise && sdaNow && !startDet && !stopDet
      |=> state_ff == isp_pkg::ST_SKIP && !sdaOe_ff)
      else $error("master not-acknowledge did not end the read");
   a_skip_quiet: assert property (
      state_ff == isp_pkg::ST_SKIP |-> !sdaOe_ff)
      else $error("data line driven while ignoring the bus");
   a_idle_quiet: assert property (
      state_ff == isp_pkg::ST_IDLE |-> !sdaOe_ff && !busActive_ff)
      else $error("idle port drives the line or reports busy");
   a_ptr_steady: assert property (
      !rxEnd |=> ptr_ff == $past(ptr_ff))
      else $error("pointer moved outside a byte boundary");
endmodule

// ===== isp_pkg.sv
// Constants and state encoding for the two-wire register slave port
package isp_pkg;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;
   localparam logic [6:0] SLAVE_ADDR = 7'h58;
   localparam logic RW_READ = 1'b1;
   localparam int REG_COUNT = 16;
   localparam int REG_IDX_W = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 2 * BYTE_W;
   localparam logic SDA_DRIVE_LVL = 1'b0;
   localparam logic [1:0] PIN_IDLE = 2'h3;
   localparam logic [BYTE_W-1:0] PTR_STEP = 8'h01;
   localparam int CLK_PERIOD_NS = 50;
   localparam int LINK_PERIOD_NS = 400;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_ADDR  = 8'h02,
      ST_IDX   = 8'h04,
      ST_WDATA = 8'h08,
      ST_ACK   = 8'h10,
      ST_RDATA = 8'h20,
      ST_RACK  = 8'h40,
      ST_SKIP  = 8'h80
   } isp_state_t;
endpackage

// ===== isp_stream_if.sv
// Valid/ready word stream between the port's internal modules
`timescale 1ns/1ns
interface isp_stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ===== isp_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module isp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Stream ports
   isp_stream_if.snk inPort,
   isp_stream_if.src outPort
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff, rdPtr_ff;
   logic [AW:0] count_ff;
   logic full, empty, doPush, doPop;

   assign full = (count_ff == (AW+1)'(DEPTH));
   assign empty = (count_ff == '0);
   assign inPort.ready = !full;
   assign outPort.valid = !empty;
   assign outPort.data = mem[rdPtr_ff];
   assign doPush = inPort.valid && !full;
   assign doPop = outPort.ready && !empty;

   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr_ff] <= inPort.data;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         wrPtr_ff <= doPush ? AW'((wrPtr_ff + 1'b1) % DEPTH) : wrPtr_ff;
         rdPtr_ff <= doPop ? AW'((rdPtr_ff + 1'b1) % DEPTH) : rdPtr_ff;
         count_ff <= count_ff + (AW+1)'(doPush) - (AW+1)'(doPop);
      end
   end

   a_full_refuses: assert property (@(posedge clock) disable iff (!resetn)
      full && !doPop |=> count_ff == $past(count_ff))
      else $error("fifo count moved while full and not draining");
endmodule

// ===== isp_regmem.sv
// Register storage with a buffered write port and a registered read port
`timescale 1ns/1ns
module isp_regmem (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Buffered writes, word is index over data
   isp_stream_if.snk wrPort,
   // Read port
   input wire logic rdEn,
   input wire logic [isp_pkg::BYTE_W-1:0] rdIdx,
   output logic [isp_pkg::BYTE_W-1:0] rdData
);
   logic [isp_pkg::BYTE_W-1:0] regs [isp_pkg::REG_COUNT];
   logic [isp_pkg::BYTE_W-1:0] rdData_ff;
   logic [isp_pkg::REG_IDX_W-1:0] wrIdx, rdSel;
   logic doWrite;

   // Single port: a read in progress holds writes back in the buffer
   assign wrPort.ready = !rdEn;
   assign doWrite = wrPort.valid && !rdEn;
   assign wrIdx = wrPort.data[isp_pkg::BYTE_W +: isp_pkg::REG_IDX_W];
   // Indices above the array alias; only the low four bits pick a register
   assign rdSel = rdIdx[isp_pkg::REG_IDX_W-1:0];
   assign rdData = rdData_ff;

   always_ff @(posedge clock) begin
      if (doWrite) begin
         regs[wrIdx] <= wrPort.data[isp_pkg::BYTE_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdData_ff <= '0;
      end else if (rdEn) begin
         rdData_ff <= regs[rdSel];
      end
   end
endmodule

// ===== isp_master_model.sv
// Behavioural two-wire bus master standing on the far side of the port
`timescale 1ns/1ns
module isp_master_model (
   // Bus pins
   output logic scl,
   output logic sdaPull,
   input wire logic sda
);
   // Idle bus: clock stands high, data released
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end

   task automatic bit_slot(input logic v, output logic s);
      #50 sdaPull = ~v;
      #150 scl = 1'b1;
      // Sampled late in the high phase, the slave answers well after the fall
      #190 s = sda;
      #10 scl = 1'b0;
   endtask

   task automatic start();
      #50 sdaPull = 1'b0;
      #150 scl = 1'b1;
      #150 sdaPull = 1'b1;
      #200 scl = 1'b0;
   endtask

   task automatic stop();
      #50 sdaPull = 1'b1;
      #150 scl = 1'b1;
      #200 sdaPull = 1'b0;
      #200;
   endtask

   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
      bit_slot(1'b1, s);
      ack = ~s;
   endtask

   task automatic read_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, s);
         b[i] = s;
      end
      bit_slot(last, s);
   endtask
endmodule

// ===== tb.sv
// Self-checking bench for the two-wire register slave port
`timescale 1ns/1ns
module tb;
   logic clock;
   logic resetn;
   logic scl;
   logic sdaPull;
   logic sda;
   logic sdaOut;
   logic sdaOe;
   logic busActive;
   int numErrors;
   int nChecks;

   // Open drain data wire with pull-up
   assign sda = ((sdaOe && !sdaOut) || sdaPull) ? 1'b0 : 1'b1;

   isp_top isp_top_i (
      .clock(clock),
      .resetn(resetn),
      .sclIn(scl),
      .sdaIn(sda),
      .sdaOut(sdaOut),
      .sdaOe(sdaOe),
      .busActive(busActive)
   );

   isp_master_model isp_master_model_i (
      .scl(scl),
      .sdaPull(sdaPull),
      .sda(sda)
   );

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      nChecks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         numErrors++;
      end
   endtask

   task automatic wrap_up();
      if (numErrors == 0 && nChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // slave moves data only with clock low
   always @(sdaOe) begin
      if (resetn === 1'b1 && scl === 1'b1) begin
         $display("ERROR sdaOe expected steady seen change");
         numErrors++;
      end
   end

   task automatic send(input logic [7:0] b, input logic expAck);
      logic ack;
      isp_master_model_i.write_byte(b, ack);
      chk("ack", {7'h00, expAck}, {7'h00, ack});
   endtask

   task automatic write_seq(input logic [7:0] idx, input logic [7:0] d[$]);
      isp_master_model_i.start();
      chk("busActive", 8'h01, {7'h00, busActive});
      send(8'hB0, 1'b1);
      send(idx, 1'b1);
      foreach (d[k]) send(d[k], 1'b1);
      isp_master_model_i.stop();
      repeat (4) @(posedge clock);
      #1;
      chk("busActive", 8'h00, {7'h00, busActive});
   endtask

   task automatic read_check(input logic [7:0] idx, input logic [7:0] exp[$]);
      logic [7:0] b;
      isp_master_model_i.start();
      send(8'hB0, 1'b1);
      send(idx, 1'b1);
      isp_master_model_i.start();
      send(8'hB1, 1'b1);
      foreach (exp[k]) begin
         isp_master_model_i.read_byte(k == exp.size() - 1, b);
         chk("read data", exp[k], b);
      end
      isp_master_model_i.stop();
   endtask

   task automatic sc_single();
      write_seq(8'h03, {8'h5A});
      read_check(8'h03, {8'h5A});
   endtask

   task automatic sc_multi();
      logic [7:0] d[$];
      d = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99};
      write_seq(8'h00, d);
      read_check(8'h00, d);
   endtask

   // Repeated start ends the first write run
   task automatic sc_restart();
      isp_master_model_i.start();
      send(8'hB0, 1'b1);
      send(8'h05, 1'b1);
      send(8'hC3, 1'b1);
      isp_master_model_i.start();
      send(8'hB0, 1'b1);
      send(8'h07, 1'b1);
      send(8'h3C, 1'b1);
      isp_master_model_i.stop();
      read_check(8'h05, {8'hC3, 8'h77, 8'h3C});
   endtask

   // Foreign address: no ack and following bytes ignored
   task automatic sc_foreign();
      logic [7:0] b;
      isp_master_model_i.start();
      send(8'hA0, 1'b0);
      send(8'h00, 1'b0);
      send(8'hEE, 1'b0);
      isp_master_model_i.stop();
      isp_master_model_i.start();
      send(8'hB1, 1'b1);
      isp_master_model_i.read_byte(1'b1, b);
      chk("pointer after foreign", 8'h99, b);
      isp_master_model_i.stop();
      read_check(8'h00, {8'h11});
   endtask

   initial begin
      numErrors = 0;
      nChecks = 0;
      resetn = 1'b0;
      repeat (20) @(posedge clock);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      chk("sdaOe", 8'h00, {7'h00, sdaOe});
      chk("busActive", 8'h00, {7'h00, busActive});
      sc_single();
      sc_multi();
      sc_restart();
      sc_foreign();
      wrap_up();
   end

   // Whole run needs about 200 us of bus traffic
   initial begin
      #2000000;
      numErrors++;
      wrap_up();
   end
endmodule
